// *** rtl/cff_defines.svh ***
/*
 * Register indices, field positions and reset values of the FIFO
 * status and filter routing block.
 * Assumes the includer has no other macros with the CFF_ prefix.
 */
`ifndef CFF_DEFINES_SVH
`define CFF_DEFINES_SVH

// register indices on the register port
`define CFF_REG_CTRL 2'h0
`define CFF_REG_STAT 2'h1
`define CFF_REG_UADDR 2'h2
`define CFF_REG_FLT 2'h3

// fifo control fields
`define CFF_C_EN_HI 4
`define CFF_C_UINC 8
`define CFF_C_SREQ 9
`define CFF_C_FCLR 10
`define CFF_C_DIR 7
`define CFF_C_DEPTH_LO 24
`define CFF_C_DEPTH_HI 28

// fifo status fields and enable positions
`define CFF_S_ATT 4
`define CFF_S_OVF 3
`define CFF_S_EF 2
`define CFF_S_HALF 1
`define CFF_S_NFNE 0
`define CFF_S_BERR 5
`define CFF_S_LARB 6
`define CFF_S_ABT 7

// filter control: one byte lane per filter
`define CFF_NFLT 4
`define CFF_LANE 8
`define CFF_F_EN 7
`define CFF_F_PTR_HI 4

// widths and reset values
`define CFF_SLOT_W 5
`define CFF_CNT_W 6
`define CFF_RST_DEPTH 5'h00
`define CFF_RST_PTR 5'h00
`define CFF_RST_CNT 6'h00
`define CFF_ONE_CNT 6'h01
`define CFF_RST_WORD 32'h0000_0000

`endif

// *** rtl/cff_pkg.sv ***
/*
 * Types shared by the FIFO status and filter routing block.
 * Assumes nothing of its surroundings.
 */
package cff_pkg;

	// fifo clear sequencer: held in configuration, pulsed on exit
	typedef enum logic [1:0] {
		CF_IDLE,
		CF_HOLD,
		CF_CLEAR
	} cff_clr_e;

	typedef logic [4:0] cff_slot_t;

endpackage

// *** rtl/cff_fifo_status.sv ***
/*
 * One message FIFO's control, status and user address registers, plus
 * one filter control word that enables four acceptance filters and
 * routes their hits into a receive FIFO.
 * Assumes a synchronous register port driven by the host interface
 * logic and event strobes from the protocol engine, all on clk_sys_i.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cff_defines.svh"

// Function
// - direction bit 7 selects transmit (1) or receive (0) behaviour.
// - control bit 1 enables half-empty (tx) or half-full (rx) interrupt.
// - control bit 0 enables not-full (tx) or not-empty (rx) interrupt.
// - direction and depth code change only while in configuration mode.
// - fifo clear bit held in configuration, cleared by hardware in normal.
// - status bits 12-8 give next slot to send or to store into.
// - message index runs zero to depth code.
// - status bit 7 set when last transmitted message was aborted.
// - status bit 6 set when the message lost arbitration.
// - status bit 5 set when a bus error hit the transmission.
// - abort, arbitration, error bits clear on send request or host zero.
// - those three bits update on completion, abort or fifo reset.
// - status bit 4 flags retries exhausted; reads zero for receive.
// - status bit 3 flags receive overflow; reads zero for transmit.
// - bit 2 is empty for transmit, full for receive.
// - bit 1 is at-most-half-full for transmit, half-full for receive.
// - bit 0 is not-full for transmit, not-empty for receive.
// - user address gives head for transmit, tail for receive.
// - each filter byte has an enable at its top bit.
// - each filter has a five bit destination fifo pointer.
// - a pointer is writable only while its filter is disabled.
// - fifo depth is depth code plus one messages.
module cff_fifo_status
	import cff_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// mode
	input wire logic cfg_mode_i,
	// register port
	input wire logic [1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	// protocol engine events
	input wire logic msg_done_i,
	input wire logic msg_abort_i,
	input wire logic lost_arb_i,
	input wire logic bus_err_i,
	input wire logic attempts_exh_i,
	input wire logic rx_store_i,
	// message object placement
	input wire logic [31:0] obj_base_i,
	input wire logic [11:0] obj_size_i,
	// engine requests and interrupt
	output logic send_request_o,
	output logic abort_req_o,
	output logic fifo_irq_o,
	// filter routing
	input wire logic [3:0] flt_match_i,
	output logic [3:0] filter_accept_en_o,
	output logic route_valid_o,
	output logic [4:0] route_fifo_o
);

	logic fifo_direction_tx;
	logic [`CFF_C_EN_HI:0] irq_en;
	cff_slot_t fifo_depth_code;
	logic send_request;
	cff_clr_e clr_state;
	cff_clr_e next_clr_state;
	logic [`CFF_CNT_W-1:0] count;
	cff_slot_t head;
	cff_slot_t tail;
	logic tx_aborted;
	logic tx_lost_arb;
	logic tx_bus_error;
	logic attempts_exhausted;
	logic rx_overflow;
	logic [`CFF_NFLT-1:0] filter_accept_en;
	cff_slot_t flt_ptr [`CFF_NFLT];
	logic [31:0] flt_word;
	logic [31:0] rd_mux;

	// register port decode
	wire wr_ctrl = reg_wr_i && (reg_addr_i == `CFF_REG_CTRL);
	wire wr_stat = reg_wr_i && (reg_addr_i == `CFF_REG_STAT);
	wire wr_flt = reg_wr_i && (reg_addr_i == `CFF_REG_FLT);
	wire [`CFF_CNT_W-1:0] depth = {1'b0, fifo_depth_code} + `CFF_ONE_CNT;
	wire full = (count == depth);
	wire empty = (count == `CFF_RST_CNT);
	wire clearing = (clr_state == CF_CLEAR);
	wire fifo_clear = (clr_state != CF_IDLE);
	wire running = !cfg_mode_i && !fifo_clear;
	// host increment is ignored while the fifo is held or clearing
	wire host_inc = wr_ctrl && reg_wdata_i[`CFF_C_UINC] && running;
	// direction steers who fills and who drains
	wire push = running && !full &&
		(fifo_direction_tx ? host_inc : rx_store_i);
	wire pop = running && !empty &&
		(fifo_direction_tx ? msg_done_i : host_inc);
	wire ovf_evt = running && !fifo_direction_tx && rx_store_i && full;
	wire evt_done = fifo_direction_tx && (msg_done_i || msg_abort_i);
	wire sreq_set = wr_ctrl && reg_wdata_i[`CFF_C_SREQ] && fifo_direction_tx;
	wire sreq_drop = wr_ctrl && !reg_wdata_i[`CFF_C_SREQ] && send_request;
	wire last_out = pop && !push && (count == `CFF_ONE_CNT);
	// slot wrap at the configured depth
	wire [`CFF_SLOT_W-1:0] head_inc = head + 5'h01;
	wire [`CFF_SLOT_W-1:0] tail_inc = tail + 5'h01;
	wire cff_slot_t next_head =
		(head == fifo_depth_code) ? `CFF_RST_PTR : head_inc;
	wire cff_slot_t next_tail =
		(tail == fifo_depth_code) ? `CFF_RST_PTR : tail_inc;
	wire [`CFF_CNT_W-1:0] next_count =
		count + {5'h00, push} - {5'h00, pop};
	// index follows the engine's side of the queue
	wire cff_slot_t msg_index = fifo_direction_tx ? tail : head;
	// user address follows the host's side of the queue
	wire cff_slot_t ua_slot = fifo_direction_tx ? head : tail;
	wire [16:0] ua_off = obj_size_i * ua_slot;
	wire [31:0] fifo_user_addr = obj_base_i + {15'h0000, ua_off};

	// level flags are pure functions of occupancy
	// empty when transmitting, full when receiving
	wire empty_full_flag = fifo_direction_tx ? empty : full;
	// doubled count compared against depth avoids a divider
	wire [`CFF_CNT_W:0] cnt2 = {count, 1'b0};
	wire [`CFF_CNT_W:0] dep1 = {1'b0, depth};
	wire half_level_flag = fifo_direction_tx ? (cnt2 <= dep1) : (cnt2 >= dep1);
	// not full when transmitting, not empty when receiving
	wire notfull_notempty_flag = fifo_direction_tx ? !full : !empty;
	wire att_rd = attempts_exhausted && fifo_direction_tx;
	wire ovf_rd = rx_overflow && !fifo_direction_tx;
	wire [`CFF_C_EN_HI:0] flags = {att_rd, ovf_rd, empty_full_flag,
		half_level_flag, notfull_notempty_flag};

	// each enabled flag raises the request
	assign fifo_irq_o = |(flags & irq_en);
	assign send_request_o = send_request;

	// read views of the three fifo words
	wire [31:0] ctrl_word = {3'h0, fifo_depth_code, 13'h0000, fifo_clear,
		send_request, 1'b0, fifo_direction_tx, 2'h0, irq_en};
	wire [31:0] stat_word = {19'h00000, msg_index, tx_aborted, tx_lost_arb,
		tx_bus_error, flags};
	assign rd_mux = (reg_addr_i == `CFF_REG_CTRL) ? ctrl_word :
		(reg_addr_i == `CFF_REG_STAT) ? stat_word :
		(reg_addr_i == `CFF_REG_UADDR) ? fifo_user_addr : flt_word;

	// control fields; locked ones only move in configuration
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			fifo_direction_tx <= 1'b0;
			fifo_depth_code <= `CFF_RST_DEPTH;
			irq_en <= '0;
		end else if (wr_ctrl) begin
			irq_en <= reg_wdata_i[`CFF_C_EN_HI:0];
			if (cfg_mode_i) begin
				fifo_direction_tx <= reg_wdata_i[`CFF_C_DIR];
				fifo_depth_code <=
					reg_wdata_i[`CFF_C_DEPTH_HI:`CFF_C_DEPTH_LO];
			end
		end
	end

	// clear sequencer, held in configuration, self clearing after
	always_comb begin
		next_clr_state = clr_state;
		case (clr_state)
			CF_IDLE: begin
				if (cfg_mode_i)
					next_clr_state = CF_HOLD;
				else if (wr_ctrl && reg_wdata_i[`CFF_C_FCLR])
					next_clr_state = CF_CLEAR;
			end
			CF_HOLD: next_clr_state = cfg_mode_i ? CF_HOLD : CF_CLEAR;
			CF_CLEAR: next_clr_state = cfg_mode_i ? CF_HOLD : CF_IDLE;
			default: next_clr_state = CF_HOLD;
		endcase
	end

	// device comes out of reset in configuration, so the fifo is held
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			clr_state <= CF_HOLD;
		else
			clr_state <= next_clr_state;
	end

	// occupancy and slot pointers, zeroed by a fifo reset
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || clearing) begin
			count <= `CFF_RST_CNT;
			head <= `CFF_RST_PTR;
			tail <= `CFF_RST_PTR;
		end else begin
			count <= next_count;
			if (push)
				head <= next_head;
			if (pop)
				tail <= next_tail;
		end
	end

	// send request: host sets, hardware drops when the queue drains
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || clearing) begin
			send_request <= 1'b0;
			abort_req_o <= 1'b0;
		end else begin
			abort_req_o <= sreq_drop;
			if (sreq_set)
				send_request <= 1'b1;
			else if (sreq_drop || last_out || msg_abort_i)
				send_request <= 1'b0;
		end
	end

	// outcome bits, engine update beats send request and host clears; reset and fifo reset beat it
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || clearing) begin
			tx_aborted <= 1'b0;
			tx_lost_arb <= 1'b0;
			tx_bus_error <= 1'b0;
		end else if (evt_done) begin
			tx_aborted <= msg_abort_i;
			tx_lost_arb <= lost_arb_i;
			tx_bus_error <= bus_err_i;
		end else if (sreq_set) begin
			tx_aborted <= 1'b0;
			tx_lost_arb <= 1'b0;
			tx_bus_error <= 1'b0;
		end else if (wr_stat) begin
			tx_aborted <= tx_aborted & reg_wdata_i[`CFF_S_ABT];
			tx_lost_arb <= tx_lost_arb & reg_wdata_i[`CFF_S_LARB];
			tx_bus_error <= tx_bus_error & reg_wdata_i[`CFF_S_BERR];
		end
	end

	// sticky event flags; a new event wins over a host clear
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || clearing) begin
			attempts_exhausted <= 1'b0;
			rx_overflow <= 1'b0;
		end else begin
			attempts_exhausted <= (attempts_exh_i && fifo_direction_tx) ||
				(attempts_exhausted &&
				!(wr_stat && !reg_wdata_i[`CFF_S_ATT]));
			rx_overflow <= ovf_evt ||
				(rx_overflow && !(wr_stat && !reg_wdata_i[`CFF_S_OVF]));
		end
	end

	// registered read data
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i)
			reg_rdata_o <= `CFF_RST_WORD;
		else
			reg_rdata_o <= rd_mux;
	end

	// one byte lane per filter
	genvar gi;
	generate
		for (gi = 0; gi < `CFF_NFLT; gi++) begin : g_flt
			wire [7:0] lane = reg_wdata_i[gi*`CFF_LANE +: `CFF_LANE];
			always_ff @(posedge clk_sys_i) begin
				if (!rst_n_i) begin
					filter_accept_en[gi] <= 1'b0;
					flt_ptr[gi] <= `CFF_RST_PTR;
				end else if (wr_flt) begin
					filter_accept_en[gi] <= lane[`CFF_F_EN];
					// pointer locked while filter is live
					if (!filter_accept_en[gi])
						flt_ptr[gi] <= lane[`CFF_F_PTR_HI:0];
				end
			end
			assign flt_word[gi*`CFF_LANE +: `CFF_LANE] =
				{filter_accept_en[gi], 2'h0, flt_ptr[gi]};
		end
	endgenerate

	// lowest numbered enabled hit picks the destination
	wire [3:0] flt_hit = flt_match_i & filter_accept_en;
	assign filter_accept_en_o = filter_accept_en;
	assign route_valid_o = |flt_hit;
	assign route_fifo_o = flt_hit[0] ? flt_ptr[0] :
		flt_hit[1] ? flt_ptr[1] :
		flt_hit[2] ? flt_ptr[2] :
		flt_hit[3] ? flt_ptr[3] : `CFF_RST_PTR;

	// checks on the block's own behaviour
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence s_cfg_exit;
		cfg_mode_i [*2] ##1 !cfg_mode_i [*3];
	endsequence
	sequence s_outcome;
		(evt_done && !clearing) ##1 1'b1;
	endsequence
	property p_cfg_lock;
		(wr_ctrl && !cfg_mode_i) |=>
			$stable(fifo_depth_code) && $stable(fifo_direction_tx);
	endproperty
	a_cfg_lock: assert property (p_cfg_lock)
		else $error("locked field moved outside configuration");
	property p_auto_clear;
		(s_cfg_exit and (!wr_ctrl [*5])) |-> !fifo_clear;
	endproperty
	a_auto_clear: assert property (p_auto_clear)
		else $error("fifo clear not dropped after leaving configuration");
	property p_idx_range;
		running |-> (msg_index <= fifo_depth_code);
	endproperty
	a_idx_range: assert property (p_idx_range)
		else $error("message index beyond depth");
	property p_outcome;
		s_outcome |-> (tx_aborted == $past(msg_abort_i)) &&
			(tx_lost_arb == $past(lost_arb_i)) &&
			(tx_bus_error == $past(bus_err_i));
	endproperty
	a_outcome: assert property (p_outcome)
		else $error("outcome bits not updated on completion");
	property p_sreq_clears;
		(sreq_set && !evt_done && !clearing) |=>
			!tx_aborted && !tx_lost_arb && !tx_bus_error;
	endproperty
	a_sreq_clears: assert property (p_sreq_clears)
		else $error("outcome bits survive a send request");
	property p_ovf_sets;
		ovf_evt |=> rx_overflow && (clearing || (wr_stat &&
			!reg_wdata_i[`CFF_S_OVF])) or (rx_overflow ##1 rx_overflow);
	endproperty
	a_ovf_sets: assert property (p_ovf_sets)
		else $error("overflow flag lost");
	property p_irq;
		(ovf_rd && irq_en[`CFF_S_OVF]) |-> fifo_irq_o;
	endproperty
	a_irq: assert property (p_irq)
		else $error("enabled flag gives no interrupt");
	property p_ptr_lock;
		(wr_flt && filter_accept_en[0]) |=> $stable(flt_ptr[0]);
	endproperty
	a_ptr_lock: assert property (p_ptr_lock)
		else $error("pointer written while filter enabled");
	property p_rx_store;
		(running && !fifo_direction_tx && rx_store_i && !host_inc &&
			!cfg_mode_i) |=> (clearing || !empty);
	endproperty
	a_rx_store: assert property (p_rx_store)
		else $error("stored message left fifo empty");
endmodule
`default_nettype wire

// *** tb/cff_host_model.sv ***
/*
 * host side of the register port: one-edge write strobes and
 * settled reads with the one-cycle read latency.
 * assumes the bench calls its tasks and shares clk_sys_i.
 */
`timescale 1ns/10ps
`default_nettype none
module cff_host_model (
	// clock
	input wire logic clk_sys_i,
	// register port
	output logic [1:0] reg_addr_o,
	output logic reg_wr_o,
	output logic [31:0] reg_wdata_o,
	input wire logic [31:0] reg_rdata_i
);
	// idle values at time zero
	initial begin
		reg_addr_o = 2'h0;
		reg_wr_o = 1'b0;
		reg_wdata_o = 32'h0;
	end
	// data goes inverted after the strobe so stale data is never seen
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		@(negedge clk_sys_i);
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(negedge clk_sys_i);
		reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
	endtask
	// two edges pass so events of the last cycle have landed
	task automatic rd(input logic [1:0] a, output logic [31:0] d);
		@(negedge clk_sys_i);
		reg_addr_o = a;
		@(negedge clk_sys_i);
		@(negedge clk_sys_i);
		d = reg_rdata_i;
	endtask
endmodule
`default_nettype wire

// *** tb/can_fifo_status_filter_routing_test.sv ***
/*
 * self-checking bench of the fifo status and filter routing block.
 * assumes the host model drives the register port off falling edges.
 */
`timescale 1ns/10ps
`default_nettype none
`include "cff_defines.svh"
module can_fifo_status_filter_routing_test;
	// stimulus
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cfg = 1'b1;
	logic [5:0] evs = 6'h0;
	logic [3:0] match = 4'h0;
	logic [31:0] base = 32'h0;
	logic [11:0] size = 12'h0;
	// design outputs and port wires
	logic [1:0] addr;
	logic wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic sreq;
	logic abrq;
	logic irq;
	logic [3:0] fen;
	logic rv;
	logic [4:0] rf;
	// reference model
	int cnt, hd, tl, dep, err_count, compares, cycles;
	int seed = 29;
	bit dir, m_abt, m_larb, m_err, m_att, m_ovf, m_sreq;
	logic [4:0] en;
	logic [3:0] fm;
	logic [19:0] pp;
	logic [31:0] v;

	initial begin
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	cff_host_model i_cff_host_model (.clk_sys_i(clk_sys_i),
		.reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata),
		.reg_rdata_i(rdata));

	cff_fifo_status i_cff_fifo_status (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .cfg_mode_i(cfg), .reg_addr_i(addr),
		.reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.msg_done_i(evs[0]), .msg_abort_i(evs[1]),
		.lost_arb_i(evs[4]), .bus_err_i(evs[5]),
		.attempts_exh_i(evs[2]), .rx_store_i(evs[3]),
		.obj_base_i(base), .obj_size_i(size),
		.send_request_o(sreq), .abort_req_o(abrq),
		.fifo_irq_o(irq), .flt_match_i(match),
		.filter_accept_en_o(fen), .route_valid_o(rv),
		.route_fifo_o(rf));

	task automatic test_done();
		if (err_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// hang guard: far above the few hundred cycles needed
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			test_done();
		end
	end

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask

	function automatic logic [31:0] xstat();
		logic [31:0] s;
		int d;
		d = dep + 1;
		s = 32'h0;
		s[12:8] = 5'(dir ? tl : hd);
		s[7:3] = {m_abt, m_larb, m_err, m_att & dir, m_ovf & ~dir};
		s[2] = dir ? cnt == 0 : cnt == d;
		s[1] = dir ? 2 * cnt <= d : 2 * cnt >= d;
		s[0] = dir ? cnt < d : cnt > 0;
		return s;
	endfunction

	function automatic logic [31:0] fword(input logic [3:0] f,
		input logic [19:0] p);
		logic [31:0] w;
		w = 32'h0;
		for (int i = 0; i < 4; i++) begin
			w[8 * i + 7] = f[i];
			w[8 * i +: 5] = p[5 * i +: 5];
		end
		return w;
	endfunction

	task automatic wctl(input int d, input bit r, input bit s,
		input bit u);
		i_cff_host_model.wr(`CFF_REG_CTRL, 32'(d) << 24 | 32'(s) << 9
			| 32'(u) << 8 | 32'(r) << 7 | 32'(en));
	endtask

	task automatic rdctl(input bit c);
		i_cff_host_model.rd(`CFF_REG_CTRL, v);
		chk("ctrl", 32'(dep) << 24 | 32'(c) << 10 | 32'(dir) << 7,
			v & 32'h1f00_0480);
	endtask

	task automatic check_all();
		i_cff_host_model.rd(`CFF_REG_STAT, v);
		chk("status", xstat(), v);
		// user address read outside configuration only
		i_cff_host_model.rd(`CFF_REG_UADDR, v);
		chk("uaddr", base + 32'(size) * 32'(dir ? hd : tl), v);
		chk("sreq", 32'(m_sreq), 32'(sreq));
		chk("irq", 32'(|(xstat() & en)), 32'(irq));
	endtask

	// one engine strobe: 0 done, 1 abort, 2 retries out, 3 store
	task automatic ev(input int k, input bit la, input bit be);
		@(negedge clk_sys_i);
		evs = 6'(1 << k) | {be, la, 4'h0};
		if (k < 2) begin
			m_abt = k == 1;
			m_larb = la;
			m_err = be;
		end
		if (k == 0) begin
			tl = (tl + 1) % (dep + 1);
			cnt--;
			m_sreq = m_sreq && cnt > 0;
		end
		m_sreq = m_sreq && k != 1;
		m_att = m_att | k == 2;
		if (k == 3 && cnt == dep + 1) begin
			m_ovf = 1;
		end else if (k == 3) begin
			hd = (hd + 1) % (dep + 1);
			cnt++;
		end
		@(negedge clk_sys_i);
		evs = 6'h0;
		check_all();
	endtask

	// configure a fresh fifo; leaving configuration clears it
	task automatic setup(input bit r);
		cfg = 1'b1;
		dir = r;
		wctl(dep, dir, 0, 0);
		rdctl(1);
		@(negedge clk_sys_i);
		cfg = 1'b0;
		{cnt, hd, tl} = '0;
		{m_abt, m_larb, m_err, m_att, m_ovf, m_sreq} = '0;
		repeat (4) @(negedge clk_sys_i);
		rdctl(0);
		check_all();
	endtask

	initial begin
		repeat (10) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		dep = 2 + {$random(seed)} % 4;
		base = $random(seed);
		size = 12'($random(seed));
		en = 5'($random(seed));
		setup(1);
		wctl(dep ^ 1, 0, 0, 0);
		rdctl(0);
		repeat (dep + 1) begin
			wctl(dep, 1, 0, 1);
			hd = (hd + 1) % (dep + 1);
			cnt++;
			check_all();
		end
		wctl(dep, 1, 1, 0);
		m_sreq = 1;
		ev(0, 1, 1);
		ev(1, 1, 0);
		wctl(dep, 1, 1, 0);
		{m_sreq, m_abt, m_larb, m_err} = 4'h8;
		check_all();
		wctl(dep, 1, 0, 0);
		chk("abort", 32'h1, 32'(abrq));
		m_sreq = 0;
		ev(2, 0, 0);
		ev(0, 0, 1);
		i_cff_host_model.wr(`CFF_REG_STAT, 32'h0);
		{m_abt, m_larb, m_err, m_att} = 4'h0;
		check_all();
		wctl(dep, 1, 1, 0);
		m_sreq = 1;
		while (cnt > 0) begin
			ev(0, 0, 0);
		end
		en = 5'($random(seed));
		setup(0);
		repeat (dep + 2) begin
			ev(3, 0, 0);
		end
		ev(2, 0, 0);
		repeat (2) begin
			wctl(dep, 0, 0, 1);
			tl = (tl + 1) % (dep + 1);
			cnt--;
			check_all();
		end
		// host fifo reset in normal mode empties the queue and its flags
		i_cff_host_model.wr(`CFF_REG_CTRL, 32'(dep) << 24 | 32'h0000_0400
			| 32'(en));
		{cnt, hd, tl, m_ovf} = '0;
		rdctl(0);
		check_all();
		// pointers stay in 1 to 31
		for (int i = 0; i < 4; i++) begin
			pp[5 * i +: 5] = 5'(1 + {$random(seed)} % 31);
		end
		i_cff_host_model.wr(`CFF_REG_FLT, fword(4'h0, pp));
		i_cff_host_model.wr(`CFF_REG_FLT, fword(4'hf, pp));
		fm = 4'($random(seed));
		i_cff_host_model.wr(`CFF_REG_FLT, fword(fm, ~pp));
		i_cff_host_model.rd(`CFF_REG_FLT, v);
		chk("filter", fword(fm, pp), v);
		chk("fen", 32'(fm), 32'(fen));
		repeat (8) begin
			@(negedge clk_sys_i);
			match = 4'($random(seed));
			#1;
			v = 32'h0;
			for (int i = 3; i >= 0; i--) begin
				if (match[i] & fm[i]) begin
					v = {26'h1, pp[5 * i +: 5]};
				end
			end
			chk("route", v, {26'(rv), rf});
		end
		test_done();
	end
endmodule
`default_nettype wire
